// >>> src/adc_ctrl_consts.vh
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// Register byte offsets
`define OFS_STATUS_CTRL_FIRST  5'h00
`define OFS_STATUS_CTRL_SECOND 5'h04
`define OFS_RESULT_HIGH        5'h08
`define OFS_RESULT_LOW         5'h0c
`define OFS_COMPARE_VALUE_HIGH 5'h10
`define OFS_COMPARE_VALUE_LOW  5'h14
`define OFS_CONV_CONFIG_REG    5'h18
`define OFS_PIN_DISABLE        5'h1c

// status_ctrl_first fields
`define SC1_CONV_COMPLETE_FLAG_BIT   7
`define SC1_IRQEN_BIT  6
`define SC1_CONT_BIT   5
`define SC1_CH_HI      4
`define CH_ALL_ONES    5'h1f
// status_ctrl_second fields
`define SC2_BUSY_BIT   7
`define SC2_HWTRG_BIT  6
`define SC2_CMPEN_BIT  5
`define SC2_CMPGT_BIT  4
// conv_config_reg fields
`define CFG_LPC_BIT    7
`define CFG_DIV_HI     6
`define CFG_DIV_LO     5
`define CFG_LSMP_BIT   4
`define CFG_MODE_HI    3
`define CFG_MODE_LO    2
`define CFG_CLK_HI     1
`define CFG_CLK_LO     0

// Clock source and mode encodings
`define CLK_BUS        2'h0
`define CLK_BUS_HALF   2'h1
`define CLK_ALT        2'h2
`define CLK_ASYNC      2'h3
`define MODE_10BIT     2'h2

// Reset values
`define SC1_RESET      8'h1f
`define REG_RESET      8'h00

// Timing, in converter clock cycles unless marked
`define FIRST_EXTRA_CONVERTER_CLOCK   6'h03
`define SAMPLE_SHORT_CONVERTER_CLOCK  6'h04
`define SAMPLE_LONG_CONVERTER_CLOCK   6'h18
`define APPROX_8_CONVERTER_CLOCK      6'h0d
`define APPROX_10_CONVERTER_CLOCK     6'h10
`define SYNC_BUS_CYCLES    3'h5
// 5 us of oscillator start-up in 8 ns bus cycles, rounded up
`define ASYNC_STARTUP_CYC  10'h271
`define ASYNC_DIV_DEFAULT  4'h4

`endif

// >>> src/adc_conversion_control.v
// Overview of operation
// - Four clock sources, bus clock after reset
// - Divide selected source by 1,2,4,8
// - Async clock keeps running in low power
// - Pin disable: hi-Z, no input, no pullup
// - Disabled input buffer reads as zero
// - Hardware trigger rising edge starts conversion
// - Trigger edge ignored while converting
// - Continuous hardware mode heeds first edge only
// - Resolution selectable: 10-bit or 8-bit
// - First control write starts unless channel ones or hardware trigger enabled
// - Continuous mode restarts after each transfer
// - Completion: store result, flag, interrupt
// - High read pending blocks 10-bit transfer
// - Blocked transfer restarts, except failed single compare
// - Control, config and compare writes abort, first one restarts
// - Reset or sync-clock stop entry aborts
// - Abort keeps last result, reset clears
// - Idle until started; async clock when active
// - Sample short or long, then approximate
// - Short-sample first conversion: 20/23 plus 5
// - Long-sample first conversion: 40/43 plus 5
// - Async source adds 5 us start-up
// - Later continuous: 17/20 or 37/40
// - Disabled in reset or channel all ones
// - 8-bit rounds into low register only
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"

module adc_conversion_control #(
    parameter [3:0] ASYNC_DIV = `ASYNC_DIV_DEFAULT
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        alternate_clock,
    input  wire        hw_trigger_in,
    input  wire        stop_mode,
    input  wire [9:0]  conv_data_in,
    output wire [4:0]  channel_select,
    output wire        analog_sample,
    output wire        analog_convert,
    output wire        converter_clock,
    output wire        async_conv_clock,
    output wire        low_power_active,
    output reg         conv_irq,
    input  wire [7:0]  gpio_out,
    input  wire [7:0]  gpio_oe,
    input  wire [7:0]  gpio_pullup,
    input  wire [7:0]  pad_in,
    output wire [7:0]  pad_out,
    output wire [7:0]  pad_oe,
    output wire [7:0]  pad_pullup,
    output wire [7:0]  pad_input_enable,
    output reg  [7:0]  port_read_data
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_SYNC  = 3'h2;
    localparam [2:0] ST_RUN   = 3'h3;
    localparam [2:0] ST_DONE  = 3'h4;
    localparam [9:0] STARTUP_CYC = `ASYNC_STARTUP_CYC;

    reg  [7:0]  sc1;
    reg  [7:0]  sc2;
    reg  [7:0]  cfg;
    reg  [7:0]  cvh;
    reg  [7:0]  cvl;
    reg  [7:0]  result_high;
    reg  [7:0]  result_low;
    reg  [7:0]  analog_pin_disable;
    reg         conv_complete_flag;
    reg         hi_read_pend;
    reg  [2:0]  state;
    reg  [9:0]  wait_cnt;
    reg  [5:0]  converter_clock_left;
    reg         first_conv;
    reg         half_t;
    reg  [2:0]  div_cnt;
    reg  [3:0]  async_cnt;
    reg         async_tick;
    reg         alt_s1;
    reg         alt_s2;
    reg         alt_s3;
    reg         hw_s1;
    reg         hw_s2;
    reg         hw_s3;
    reg  [7:0]  pad_s1;
    reg  [7:0]  pad_s2;
    reg         stop_q;
    reg         src_tick;
    reg  [31:0] next_prdata;

    wire        wr = psel & penable & pwrite;
    wire        rd = psel & penable & ~pwrite;
    wire [4:0]  ofs = paddr[4:0];
    wire        mapped = (paddr[31:5] == 27'h0) & (paddr[1:0] == 2'h0);

    wire [1:0]  clk_src_sel = cfg[`CFG_CLK_HI:`CFG_CLK_LO];
    wire [1:0]  clk_divide_sel = cfg[`CFG_DIV_HI:`CFG_DIV_LO];
    wire        long_sample_sel = cfg[`CFG_LSMP_BIT];
    wire        ten_bit = (cfg[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_10BIT);
    wire        conv_irq_enable = sc1[`SC1_IRQEN_BIT];
    wire        continuous_enable = sc1[`SC1_CONT_BIT];
    wire        hw_trigger_enable = sc2[`SC2_HWTRG_BIT];
    wire        compare_func_enable = sc2[`SC2_CMPEN_BIT];
    wire        cmp_gt = sc2[`SC2_CMPGT_BIT];
    wire        ch_off = (sc1[`SC1_CH_HI:0] == `CH_ALL_ONES);
    wire        active = (state != ST_IDLE);

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign channel_select = sc1[`SC1_CH_HI:0];
    assign low_power_active = cfg[`CFG_LPC_BIT];

    // Pins used as analog inputs lose their digital interface
    assign pad_oe = gpio_oe & ~analog_pin_disable;
    assign pad_out = gpio_out & ~analog_pin_disable;
    assign pad_pullup = gpio_pullup & ~analog_pin_disable;
    assign pad_input_enable = ~analog_pin_disable;

    function is_reg;
        input [4:0] a;
        input [4:0] target;
        begin
            is_reg = mapped & (a == target);
        end
    endfunction

    // Approximation steps for the chosen resolution
    function [5:0] approx_len;
        input ten;
        begin
            approx_len = ten ? `APPROX_10_CONVERTER_CLOCK : `APPROX_8_CONVERTER_CLOCK;
        end
    endfunction

    // Converter clock cycles in one conversion
    function [5:0] conv_len;
        input first;
        input lsmp;
        input ten;
        begin
            conv_len = (lsmp ? `SAMPLE_LONG_CONVERTER_CLOCK : `SAMPLE_SHORT_CONVERTER_CLOCK)
                     + approx_len(ten)
                     + (first ? `FIRST_EXTRA_CONVERTER_CLOCK : 6'h00);
        end
    endfunction

    function [2:0] div_mask;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    div_mask = 3'h0;
                2'h1:    div_mask = 3'h1;
                2'h2:    div_mask = 3'h3;
                default: div_mask = 3'h7;
            endcase
        end
    endfunction

    // Internal oscillator only runs while a conversion is active
    wire async_gen_on = (clk_src_sel == `CLK_ASYNC) & active;
    assign async_conv_clock = async_tick;

    always @* begin
        case (clk_src_sel)
            `CLK_BUS:      src_tick = 1'b1;
            `CLK_BUS_HALF: src_tick = half_t;
            `CLK_ALT:      src_tick = alt_s2 & ~alt_s3;
            default:       src_tick = async_tick;
        endcase
    end

    wire converter_clock_tick = src_tick & ((div_cnt & div_mask(clk_divide_sel)) == div_mask(clk_divide_sel));
    assign converter_clock = converter_clock_tick;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_t <= 1'b0;
            div_cnt <= 3'h0;
            async_cnt <= 4'h0;
            async_tick <= 1'b0;
            alt_s1 <= 1'b0;
            alt_s2 <= 1'b0;
            alt_s3 <= 1'b0;
            hw_s1 <= 1'b0;
            hw_s2 <= 1'b0;
            hw_s3 <= 1'b0;
            pad_s1 <= 8'h00;
            pad_s2 <= 8'h00;
            port_read_data <= 8'h00;
            stop_q <= 1'b0;
        end else begin
            half_t <= ~half_t;
            alt_s1 <= alternate_clock;
            alt_s2 <= alt_s1;
            alt_s3 <= alt_s2;
            hw_s1 <= hw_trigger_in;
            hw_s2 <= hw_s1;
            hw_s3 <= hw_s2;
            pad_s1 <= pad_in;
            pad_s2 <= pad_s1;
            port_read_data <= pad_s2 & ~analog_pin_disable;
            stop_q <= stop_mode;
            // The async oscillator ignores wait and stop so it can keep converting
            if (async_gen_on) begin
                async_cnt <= (async_cnt == ASYNC_DIV - 4'h1) ? 4'h0 : async_cnt + 4'h1;
                async_tick <= (async_cnt == ASYNC_DIV - 4'h1);
            end else begin
                async_cnt <= 4'h0;
                async_tick <= 1'b0;
            end
            if (!active)
                div_cnt <= 3'h0;
            else if (src_tick)
                div_cnt <= div_cnt + 3'h1;
        end
    end

    // Result shaping and compare
    wire [8:0]  rnd9 = {1'b0, conv_data_in[9:2]} + {8'h00, conv_data_in[1]};
    wire [7:0]  res8 = rnd9[8] ? 8'hff : rnd9[7:0];
    wire [9:0]  conv_val = ten_bit ? conv_data_in : {2'h0, res8};
    wire [9:0]  cmp_val = ten_bit ? {cvh[1:0], cvl} : {2'h0, cvl};
    wire [10:0] diff = {1'b0, conv_val} - {1'b0, cmp_val};
    wire        cmp_ok = ~compare_func_enable | (cmp_gt ? ~diff[10] : diff[10]);
    wire [9:0]  store_val = compare_func_enable ? diff[9:0] : conv_val;
    wire        blocked = ten_bit & hi_read_pend;

    wire        sc1_wr = wr & is_reg(ofs, `OFS_STATUS_CTRL_FIRST);
    wire [4:0]  new_ch = pwdata[`SC1_CH_HI:0];
    wire        new_hwtrg = hw_trigger_enable;
    wire        sw_start = sc1_wr & (new_ch != `CH_ALL_ONES) & ~new_hwtrg;
    wire        mode_wr = wr & (is_reg(ofs, `OFS_STATUS_CTRL_SECOND) | is_reg(ofs, `OFS_CONV_CONFIG_REG)
                        | is_reg(ofs, `OFS_COMPARE_VALUE_HIGH) | is_reg(ofs, `OFS_COMPARE_VALUE_LOW));
    wire        stop_abort = stop_mode & ~stop_q & (clk_src_sel != `CLK_ASYNC);
    // Any edge while active (including a continuous run) is dropped
    wire        hw_start = hw_trigger_enable & hw_s2 & ~hw_s3 & ~active & ~ch_off;
    wire        done_xfer = (state == ST_DONE) & cmp_ok & ~blocked;
    wire        conv_complete_flag_clr = sc1_wr | (rd & is_reg(ofs, `OFS_RESULT_LOW));

    assign analog_sample = (state == ST_RUN) & (converter_clock_left > approx_len(ten_bit));
    assign analog_convert = (state == ST_RUN) & ~analog_sample;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            wait_cnt <= 10'h000;
            converter_clock_left <= 6'h00;
            first_conv <= 1'b0;
        end else if (sw_start | (state == ST_IDLE & hw_start)) begin
            first_conv <= 1'b1;
            wait_cnt <= 10'h000;
            state <= (clk_src_sel == `CLK_ASYNC) ? ST_START : ST_SYNC;
        end else if (sc1_wr | mode_wr | stop_abort | ch_off) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_START: begin
                    // Oscillator start-up before counting converter cycles
                    wait_cnt <= wait_cnt + 10'h001;
                    if (wait_cnt == STARTUP_CYC - 10'h001) begin
                        wait_cnt <= 10'h000;
                        state <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    wait_cnt <= wait_cnt + 10'h001;
                    if (wait_cnt == {7'h00, `SYNC_BUS_CYCLES} - 10'h001) begin
                        converter_clock_left <= conv_len(first_conv, long_sample_sel, ten_bit);
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (converter_clock_tick) begin
                        converter_clock_left <= converter_clock_left - 6'h01;
                        if (converter_clock_left == 6'h01)
                            state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    first_conv <= 1'b0;
                    if (blocked & ~(~continuous_enable & compare_func_enable & ~cmp_ok)) begin
                        converter_clock_left <= conv_len(1'b0, long_sample_sel, ten_bit);
                        state <= ST_RUN;
                    end else if (continuous_enable) begin
                        converter_clock_left <= conv_len(1'b0, long_sample_sel, ten_bit);
                        state <= ST_RUN;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Register file, results and flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc1 <= `SC1_RESET;
            sc2 <= `REG_RESET;
            cfg <= `REG_RESET;
            cvh <= `REG_RESET;
            cvl <= `REG_RESET;
            analog_pin_disable <= `REG_RESET;
            result_high <= `REG_RESET;
            result_low <= `REG_RESET;
            conv_complete_flag <= 1'b0;
            hi_read_pend <= 1'b0;
            conv_irq <= 1'b0;
        end else begin
            if (sc1_wr)
                sc1 <= {1'b0, pwdata[6:0]};
            if (wr & is_reg(ofs, `OFS_STATUS_CTRL_SECOND))
                sc2 <= {2'h0, pwdata[5:4], 4'h0} | {1'b0, pwdata[`SC2_HWTRG_BIT], 6'h00};
            if (wr & is_reg(ofs, `OFS_CONV_CONFIG_REG))
                cfg <= pwdata[7:0];
            if (wr & is_reg(ofs, `OFS_COMPARE_VALUE_HIGH))
                cvh <= {6'h00, pwdata[1:0]};
            if (wr & is_reg(ofs, `OFS_COMPARE_VALUE_LOW))
                cvl <= pwdata[7:0];
            if (wr & is_reg(ofs, `OFS_PIN_DISABLE))
                analog_pin_disable <= pwdata[7:0];
            // Aborts never touch results; only a transfer does
            if (done_xfer) begin
                result_high <= ten_bit ? {6'h00, store_val[9:8]} : 8'h00;
                result_low <= store_val[7:0];
            end
            // A completion in the same cycle as a clear keeps the flag set
            conv_complete_flag <= done_xfer | (conv_complete_flag & ~conv_complete_flag_clr);
            conv_irq <= (done_xfer & conv_irq_enable) | (conv_irq & ~conv_complete_flag_clr);
            if (rd & is_reg(ofs, `OFS_RESULT_HIGH) & ten_bit)
                hi_read_pend <= 1'b1;
            else if (rd & is_reg(ofs, `OFS_RESULT_LOW))
                hi_read_pend <= 1'b0;
        end
    end

    always @* begin
        next_prdata = 32'h0000_0000;
        if (mapped) begin
            case (ofs)
                `OFS_STATUS_CTRL_FIRST:  next_prdata[7:0] = {conv_complete_flag, sc1[6:0]};
                `OFS_STATUS_CTRL_SECOND: next_prdata[7:0] = {active, sc2[6:0]};
                `OFS_RESULT_HIGH:        next_prdata[7:0] = result_high;
                `OFS_RESULT_LOW:         next_prdata[7:0] = result_low;
                `OFS_COMPARE_VALUE_HIGH: next_prdata[7:0] = cvh;
                `OFS_COMPARE_VALUE_LOW:  next_prdata[7:0] = cvl;
                `OFS_CONV_CONFIG_REG:    next_prdata[7:0] = cfg;
                `OFS_PIN_DISABLE:        next_prdata[7:0] = analog_pin_disable;
                default:                 next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always @* begin
        prdata = (psel & ~pwrite) ? next_prdata : 32'h0000_0000;
    end

endmodule // adc_conversion_control

// >>> test/adc_conversion_control_monitor.sv
`timescale 1ns/1ps
module adc_ctrl_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  channel_select,
    input wire logic        analog_sample,
    input wire logic        analog_convert,
    input wire logic        conv_irq,
    input wire logic [7:0]  gpio_oe,
    input wire logic [7:0]  pad_oe,
    input wire logic [7:0]  pad_input_enable,
    input wire logic [7:0]  port_read_data
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    // A write may abort sampling, so only undisturbed phases are judged
    sequence sample_end;
        analog_sample && !(acc && pwrite) ##1 !analog_sample;
    endsequence
    ready_now_a: assert property (acc |-> pready)
        else $error("pready low in access");
    bad_addr_a: assert property (acc && paddr >= 32'h20 |-> pslverr)
        else $error("no error on unmapped address");
    pin_gate_a: assert property (pad_oe == (gpio_oe & pad_input_enable))
        else $error("pad enable not gated");
    port_zero_a: assert property ($stable(pad_input_enable) [*3] |-> !(port_read_data & ~pad_input_enable))
        else $error("disabled pin reads nonzero");
    sample_conv_a: assert property (sample_end |-> analog_convert)
        else $error("sampling not followed by approximation");
    no_overlap_a: assert property (!(analog_sample && analog_convert))
        else $error("sample and convert together");
    off_idle_a: assert property (channel_select == 5'h1f |-> !analog_sample && !analog_convert)
        else $error("active with channel off");
    flag_after_a: assert property ($rose(conv_irq) |-> $past(analog_convert, 2) && !$past(analog_convert))
        else $error("irq without completed conversion");
    irq_holds_a: assert property ($fell(conv_irq) |-> $past(acc && (pwrite ? paddr == 0 : paddr == 32'h0c)))
        else $error("irq cleared without cause");
endmodule // adc_ctrl_checker

bind adc_conversion_control adc_ctrl_checker mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .channel_select,
    .analog_sample, .analog_convert, .conv_irq, .gpio_oe, .pad_oe, .pad_input_enable, .port_read_data
);

// >>> test/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
    input  wire logic       pclk,
    input  wire logic       analog_convert,
    input  wire logic [9:0] level,
    output logic [9:0]      conv_data_in = 10'h000,
    output logic            hw_trigger_in = 1'b0,
    output logic            alternate_clock = 1'b0
);
    logic [1:0] hold = 2'h0;
    logic [2:0] div = 3'h0;
    // Result is valid during approximation and for four cycles past it; otherwise it churns so a stale sample shows
    always @(posedge pclk) begin
        hold <= analog_convert ? 2'h3 : hold - {1'b0, |hold};
        conv_data_in <= (analog_convert || |hold) ? level : ~conv_data_in;
        div <= div + 3'h1;
        alternate_clock <= div[2];
    end
    task automatic trig;
        @(posedge pclk);
        hw_trigger_in <= 1'b1;
        repeat (4) @(posedge pclk);
        hw_trigger_in <= 1'b0;
    endtask
endmodule // adc_core_model

// >>> test/tb_adc_conversion_control.sv
`timescale 1ns/1ps
module tb_adc_conversion_control;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  pad_in = 8'h00;
    logic        stop_mode = 1'b0;
    logic [9:0]  level = 10'h2a6;
    logic [31:0] r;
    logic        e;
    logic [7:0]  cfgs [7] = '{8'h18, 8'h38, 8'h58, 8'h78, 8'h19, 8'h1a, 8'h1b};
    int          exps [7] = '{32, 16, 8, 4, 16, 4, 8};
    int          n;
    int          m;
    int          t0;
    int          cyc = 0;
    int          bad_count = 0;
    int          total_checks = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, conv_irq, converter_clock, analog_sample, analog_convert;
    wire         hw_trigger_in, alternate_clock, async_conv_clock, low_power_active;
    wire  [4:0]  channel_select;
    wire  [9:0]  conv_data_in;
    wire  [7:0]  pad_out, pad_oe, pad_pullup, pad_input_enable, port_read_data;

    adc_conversion_control uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .alternate_clock, .hw_trigger_in, .stop_mode, .conv_data_in, .channel_select,
        .analog_sample, .analog_convert, .converter_clock, .async_conv_clock, .low_power_active,
        .conv_irq, .gpio_out(8'hff), .gpio_oe(8'hff), .gpio_pullup(8'hff), .pad_in, .pad_out,
        .pad_oe, .pad_pullup, .pad_input_enable, .port_read_data
    );
    adc_core_model core (.pclk, .analog_convert, .level, .conv_data_in, .hw_trigger_in, .alternate_clock);

    initial begin
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wirq(input int lim);
        n = 0;
        while (conv_irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        tally_and_finish;
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, 32'h00, 0);
        chk("sc1 reset", r, 32'h1f);
        bus(0, 32'h18, 0);
        chk("cfg reset", r, 0);
        chk("chan off", {low_power_active, channel_select}, 6'h1f);
        bus(0, 32'h20, 0);
        chk("unmapped", e, 1);
        pad_in <= 8'hff;
        bus(1, 32'h1c, 32'h0f);
        repeat (4) @(posedge pclk);
        chk("pad oe", pad_oe, 8'hf0);
        chk("pad pull out", {pad_pullup, pad_out}, 16'hf0f0);
        chk("pad input", {pad_input_enable, port_read_data}, 16'hf0f0);
        // Single conversions leave the results unread until done
        for (int i = 0; i < 4; i++) begin
            bus(1, 32'h18, {27'h0, i[0], i[1], 3'h0});
            bus(1, 32'h00, 32'h41);
            wirq(100);
            chk("conv time", n, (i[0] ? 40 : 20) + (i[1] ? 3 : 0) + 6);
            bus(0, 32'h08, 0);
            chk("result high", r, i[1] ? 2 : 0);
            bus(0, 32'h0c, 0);
            chk("result low", r, i[1] ? 32'ha6 : 32'haa);
            bus(0, 32'h00, 0);
            chk("flag clear", r, 32'h41);
        end
        bus(1, 32'h18, 0);
        bus(1, 32'h00, 32'h21);
        @(posedge analog_sample);
        @(posedge analog_sample);
        #1;
        t0 = cyc;
        @(posedge analog_sample);
        #1;
        chk("cont gap", cyc - t0, 18);
        bus(1, 32'h00, 32'h1f);
        repeat (60) @(posedge pclk);
        bus(0, 32'h00, 0);
        chk("off idle", r, 32'h1f);
        bus(1, 32'h18, 32'h08);
        bus(1, 32'h00, 32'h41);
        bus(0, 32'h08, 0);
        repeat (40) @(posedge pclk);
        chk("blocked", conv_irq, 0);
        bus(0, 32'h0c, 0);
        wirq(100);
        chk("reissued", conv_irq, 1);
        bus(0, 32'h0c, 0);
        level <= 10'h155;
        bus(1, 32'h00, 32'h41);
        repeat (10) @(posedge pclk);
        bus(1, 32'h04, 0);
        repeat (60) @(posedge pclk);
        chk("aborted", conv_irq, 0);
        bus(1, 32'h00, 32'h41);
        stop_mode <= 1'b1;
        repeat (60) @(posedge pclk);
        stop_mode <= 1'b0;
        chk("stop abort", conv_irq, 0);
        bus(0, 32'h0c, 0);
        chk("kept", r, 32'ha6);
        bus(1, 32'h00, 32'h41);
        repeat (10) @(posedge pclk);
        bus(1, 32'h00, 32'h41);
        wirq(100);
        chk("restart time", n, 29);
        bus(0, 32'h08, 0);
        chk("new high", r, 1);
        bus(0, 32'h0c, 0);
        chk("new low", r, 32'h55);
        bus(1, 32'h18, 0);
        bus(1, 32'h04, 32'h40);
        bus(1, 32'h00, 32'h41);
        repeat (40) @(posedge pclk);
        chk("hw no sw start", conv_irq, 0);
        fork
            wirq(100);
            begin
                core.trig();
                repeat (8) @(posedge pclk);
                core.trig();
            end
        join
        chk("hw time", n >= 27 && n <= 31, 1);
        bus(0, 32'h0c, 0);
        repeat (60) @(posedge pclk);
        chk("busy edge", conv_irq, 0);
        bus(1, 32'h04, 0);
        foreach (cfgs[i]) begin
            bus(1, 32'h18, {24'h0, cfgs[i]});
            bus(1, 32'h00, 32'h01);
            // Stop entry must not halt the internal oscillator
            stop_mode <= (i == 6);
            repeat (8) @(posedge pclk);
            n = 0;
            m = 0;
            repeat (32) begin
                @(posedge pclk);
                #1;
                n += (converter_clock === 1'b1);
                m += (async_conv_clock === 1'b1);
            end
            chk("clock ticks", n, exps[i]);
            chk("async ticks", m, (i == 6) ? 8 : 0);
        end
        bus(1, 32'h18, 0);
        presetn <= 1'b0;
        stop_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, 32'h0c, 0);
        chk("reset result", r, 0);
        tally_and_finish;
    end
endmodule // tb_adc_conversion_control
